// [bench/ssd_core_tb.sv]
// Self-checking bench for the decoder core over its register bus.
// Assumes one wait cycle per access and the table model beside it.
`timescale 1ns/1ps
`default_nettype none
module ssd_core_tb;
  typedef struct packed {
    logic [31:0] cmd;
    logic [2:0]  ctrl;
    logic [7:0]  exc;
    logic [4:0]  cc;
    logic        ie;
    logic [31:0] gate;
  } ssd_row_type;
  logic                   clkSys      = 1'b0;
  logic                   sysRst      = 1'b1;
  logic [7:0]             address     = 8'h00;
  logic                   read        = 1'b0;
  logic                   write       = 1'b0;
  logic [31:0]            writedata   = 32'h0;
  logic [1:0]             refSeg      = 2'h0;
  logic [12:0]            tblIdx      = 13'h0;
  logic [63:0]            tblDesc;
  logic [31:0]            readdata;
  logic                   waitrequest;
  ssd_pkg::ssd_cache_type refCache;
  logic                   intEnable;
  logic [31:0]            rd;
  int                     badCount    = 0;
  int                     nCompared   = 0;
  int                     cycles      = 0;
  // Command, control, exception, copy count, interrupt flag, gate word
  ssd_row_type            rows [0:17] = '{
    '{32'h9a08, 3'h1, 8'h00, 5'h0, 1'b1, 32'h0008_1234},
    '{32'h8108, 3'h1, 8'h00, 5'h0, 1'b1, 32'h0010_0000},
    '{32'h9a08, 3'h1, 8'h00, 5'h0, 1'b0, 32'h0018_2222},
    '{32'h9a08, 3'h1, 8'h00, 5'h0, 1'b1, 32'h0020_3333},
    '{32'hda08, 3'h1, 8'h00, 5'h5, 1'b1, 32'h0028_4444},
    '{32'hda08, 3'h1, 8'h00, 5'h0, 1'b0, 32'h0030_5555},
    '{32'h8108, 3'h1, 8'h0d, 5'h0, 1'b1, 32'h0},
    '{32'h9a08, 3'h1, 8'h0d, 5'h0, 1'b1, 32'h0},
    '{32'h9a08, 3'h1, 8'h0b, 5'h0, 1'b1, 32'h0},
    '{32'h9a08, 3'h1, 8'h0d, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h1, 8'h00, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h1, 8'h00, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h1, 8'h00, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h1, 8'h0b, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h1, 8'h0d, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h7, 8'h0d, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h7, 8'h00, 5'h0, 1'b1, 32'h0},
    '{32'h0010, 3'h7, 8'h00, 5'h0, 1'b1, 32'h0}};

  ssd_core ssd_core_i (
    .clk_sys              (clkSys),
    .sys_rst              (sysRst),
    .address              (address),
    .read                 (read),
    .write                (write),
    .byteenable           (4'hf),
    .writedata            (writedata),
    .readdata             (readdata),
    .waitrequest          (waitrequest),
    .refSeg               (refSeg),
    .refCache             (refCache),
    .intEnable            (intEnable)
  );

  ssd_table_model ssd_table_model_i (
    .index (tblIdx),
    .desc  (tblDesc)
  );

  // Clock at 40 MHz
  always #12.5 clkSys = ~clkSys;

  // Hang guard
  always @(posedge clkSys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      badCount++;
      summarize();
    end
  end

  // Verdict and end of run
  task automatic summarize();
    if (badCount == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Compare one result
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    nCompared++;
    if (got !== exp)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus write held until waitrequest is sampled low
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clkSys);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    @(posedge clkSys);
    while (waitrequest !== 1'b0)
      @(posedge clkSys);
    write <= 1'b0;
  endtask : busWrite

  // Bus read, data taken at the edge that ends the wait
  task automatic busRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clkSys);
    address <= a;
    read    <= 1'b1;
    @(posedge clkSys);
    while (waitrequest !== 1'b0)
      @(posedge clkSys);
    d = readdata;
    read <= 1'b0;
  endtask : busRead

  // Copy one table entry into the descriptor registers
  task automatic putDesc(input int i);
    tblIdx <= 13'(i);
    @(posedge clkSys);
    busWrite(ssd_pkg::OFF_DESC_LO, tblDesc[31:0]);
    busWrite(ssd_pkg::OFF_DESC_HI, tblDesc[63:32]);
  endtask : putDesc

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clkSys);
    sysRst <= 1'b0;
    busRead(ssd_pkg::OFF_CTRL, rd);
    chk("ctrl reset", 64'h0, {32'h0, rd});
    chk("cache reset", 64'h0, {16'h0, refCache});
    // Gate and system descriptor cases
    for (int i = 0; i < 18; i++)
    begin
      busWrite(ssd_pkg::OFF_CTRL, {29'h0, rows[i].ctrl});
      putDesc(i);
      busWrite(ssd_pkg::OFF_CMD, rows[i].cmd);
      busRead(ssd_pkg::OFF_STAT, rd);
      chk("exception", {56'h0, rows[i].exc}, {56'h0, rd[7:0]});
      chk("copy count", {59'h0, rows[i].cc}, {59'h0, rd[20:16]});
      chk("int enable", {63'h0, rows[i].ie}, {63'h0, intEnable});
      if (rows[i].exc == 8'h00 && rows[i].cmd[3])
      begin
        busRead(ssd_pkg::OFF_GATE, rd);
        chk("gate entry", {32'h0, rows[i].gate}, {32'h0, rd});
      end
    end
    // Cache load, refused system load, untouched on descriptor writes
    putDesc(18);
    busWrite(ssd_pkg::OFF_CMD, 32'h0000_0006);
    refSeg <= 2'h2;
    repeat (2) @(posedge clkSys);
    chk("cache seg2", {16'h0, 48'h345678_abcd_93}, {16'h0, refCache});
    putDesc(11);
    busWrite(ssd_pkg::OFF_CMD, 32'h0000_0006);
    busRead(ssd_pkg::OFF_STAT, rd);
    chk("system load", 64'h0d, {56'h0, rd[7:0]});
    chk("cache kept", {16'h0, 48'h345678_abcd_93}, {16'h0, refCache});
    putDesc(19);
    repeat (2) @(posedge clkSys);
    chk("cache no load", {16'h0, 48'h345678_abcd_93}, {16'h0, refCache});
    busWrite(ssd_pkg::OFF_CMD, 32'h0000_0004);
    refSeg <= 2'h0;
    repeat (2) @(posedge clkSys);
    chk("cache seg0", {16'h0, 48'h112233_0fff_92}, {16'h0, refCache});
    refSeg <= 2'h2;
    repeat (2) @(posedge clkSys);
    chk("cache seg2 again", {16'h0, 48'h345678_abcd_93}, {16'h0, refCache});
    // Selector split and table offset
    busWrite(ssd_pkg::OFF_SEL, 32'h0000_fffe);
    busRead(ssd_pkg::OFF_SELDEC, rd);
    chk("selector top", 64'hfff8_fffe, {32'h0, rd});
    busWrite(ssd_pkg::OFF_SEL, 32'h0000_0009);
    busRead(ssd_pkg::OFF_SELDEC, rd);
    chk("selector low", 64'h0008_0009, {32'h0, rd});
    // Unmapped and write-only places read zero
    busRead(8'h20, rd);
    chk("unmapped", 64'h0, {32'h0, rd});
    busRead(ssd_pkg::OFF_CMD, rd);
    chk("cmd read", 64'h0, {32'h0, rd});
    // Reset in mid-run clears flag and caches
    busWrite(ssd_pkg::OFF_CTRL, 32'h1);
    sysRst <= 1'b1;
    repeat (2) @(posedge clkSys);
    sysRst <= 1'b0;
    repeat (2) @(posedge clkSys);
    chk("ie after reset", 64'h0, {63'h0, intEnable});
    chk("cache after reset", 64'h0, {16'h0, refCache});
    summarize();
  end
endmodule : ssd_core_tb
`default_nettype wire

// [bench/ssd_table_model.sv]
// Descriptor table model: eight-byte entries looked up by selector index.
// Assumes the bench copies the entry it selects into the decoder registers.
`timescale 1ns/1ps
`default_nettype none
module ssd_table_model (
  input  wire logic [12:0] index, // Entry index from the selector
  output logic      [63:0] desc   // Descriptor at that index
);
  // Entries 0-17 feed the table loop, 18-19 are segment descriptors
  always_comb
  begin
    case (index)
      13'h0000: desc = 64'h0000_8405_0008_1234;
      13'h0001: desc = 64'h0000_8505_0010_beef;
      13'h0002: desc = 64'h0000_8605_0018_2222;
      13'h0003: desc = 64'h0000_8705_0020_3333;
      13'h0004: desc = 64'h0000_8405_0028_4444;
      13'h0005: desc = 64'h0000_8605_0030_5555;
      13'h0006: desc = 64'h0000_8405_0008_1234;
      13'h0007: desc = 64'h0000_8505_0010_beef;
      13'h0008: desc = 64'h0000_0405_0008_1234;
      13'h0009: desc = 64'h0000_8100_0000_ffff;
      13'h000a: desc = 64'h0000_8112_3456_0fff;
      13'h000b: desc = 64'h0000_8200_1000_00ff;
      13'h000c: desc = 64'h0000_8300_2000_01ff;
      13'h000d: desc = 64'h0000_0100_3000_02ff;
      13'h000e: desc = 64'h0000_8400_4000_03ff;
      13'h000f: desc = 64'h0000_8100_5000_04ff;
      13'h0010: desc = 64'h0000_8200_6000_05ff;
      13'h0011: desc = 64'h0000_e100_7000_06ff;
      13'h0012: desc = 64'h0000_9334_5678_abcd;
      13'h0013: desc = 64'h0000_9211_2233_0fff;
      default:  desc = 64'hffff_ffff_ffff_ffff; // Empty slot reads as junk
    endcase
  end
endmodule : ssd_table_model
`default_nettype wire

// [logic/ssd_core.sv]
// Descriptor decoder, gate checker and segment descriptor caches.
// Assumes an Avalon-MM master on clk_sys and a same-clock reference port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - System descriptors carry a 24-bit base and a 16-bit limit.
// - System type 1 is free task state, 2 local table, 3 busy task.
// - A system descriptor is valid only when its present bit is one.
// - Task state privilege is checked; local table privilege is ignored.
// - Access bit 4 clear marks a system or gate descriptor.
// - Gate types: 4 call, 5 task, 6 interrupt, 7 trap.
// - Interrupt gates clear interrupt enable; trap gates leave it.
// - Gate whose target has the wrong type raises exception 13.
// - Task gate destination offset is ignored.
// - Call gate with privilege change copies word count parameters.
// - Word count is ignored for every gate but the call gate.
// - Gate with present bit clear raises exception 11.
// - Call, interrupt and trap gates enter at the 16-bit offset.
// - Limit is the offset of the segment's last byte.
// - One hidden cache per segment register, filled on each accepted load.
// - Only segment descriptors are ever written into a cache.
// - References are served from the cache without refetching.
// - Caches are unreadable by software and change only on loads; the code also clears them on reset.
// - Selector bits 1-0 privilege, bit 2 table, bits 15-3 index.
// - Tables hold up to 8192 eight-byte entries indexed by selector.
module ssd_core #(
  parameter int SEG_COUNT = 4  // Cached segment registers
) (
  input  wire logic             clk_sys,     // 40 MHz system clock
  input  wire logic             sys_rst,     // Synchronous reset, high
  input  wire logic [7:0]       address,     // Avalon byte address
  input  wire logic             read,        // Avalon read
  input  wire logic             write,       // Avalon write
  input  wire logic [3:0]       byteenable,  // Avalon byte lanes
  input  wire logic [31:0]      writedata,   // Avalon write data
  output logic [31:0]           readdata,    // Avalon read data
  output logic                  waitrequest, // Avalon stall
  input  wire logic [1:0]       refSeg,      // Segment referenced
  output ssd_pkg::ssd_cache_type refCache,   // Cached descriptor
  output logic                  intEnable    // Interrupt enable flag
);

  // Refuse cache counts the 2-bit segment field cannot address
  if (SEG_COUNT < 1 || SEG_COUNT > 4)
  begin : g_bad_count
    $error("SEG_COUNT must be 1 to 4");
  end

  localparam logic [2:0] SegCnt = 3'(SEG_COUNT);

  // State
  logic                   ack;
  logic [31:0]            descLo;
  logic [31:0]            descHi;
  logic [15:0]            segmentSelector;
  ssd_pkg::ssd_ctrl_type  ctrl;
  ssd_pkg::ssd_stat_type  status;
  logic [15:0]            entryOffset;
  logic [15:0]            gateSelector;
  ssd_pkg::ssd_cache_type cache [SEG_COUNT];

  // Decoded views
  ssd_pkg::ssd_desc_type  dec;
  ssd_pkg::ssd_sel_type   selF;
  ssd_pkg::ssd_cmd_type   cmd;

  // Field split of the staged descriptor
  ssd_desc_decode u_dec (
    .desc   ({descHi, descLo}),
    .fields (dec)
  );

  // Selector and command views
  assign selF = ssd_pkg::ssd_split_sel(segmentSelector);
  assign cmd  = ssd_pkg::ssd_cmd_type'(writedata);

  // Bus handshake: one wait cycle, then the request is taken
  wire logic reqTake = (read | write) & !ack;
  wire logic wrGo    = write & ack;
  assign waitrequest = (read | write) & !ack;

  // Command strobes, load before gate before system check
  wire logic hitCmd = wrGo && address == ssd_pkg::OFF_CMD;
  wire logic loadGo = hitCmd & cmd.load;
  wire logic gateGo = hitCmd & !cmd.load & cmd.gate;
  wire logic sysGo  = hitCmd & !cmd.load & !cmd.gate & cmd.sysCheck;
  wire logic anyGo  = loadGo | gateGo | sysGo;

  // Effective privilege is the weaker of current and requested
  wire logic [1:0] effPriv =
    (selF.requestedPrivilegeLevel > ctrl.cpl) ?
    selF.requestedPrivilegeLevel : ctrl.cpl;

  // Gate classification; system type codes stop at 7, so access bit 3 must be clear
  wire logic sysNarrow  = dec.isSystem & !dec.access[ssd_pkg::ACC_E];
  wire logic isGate     = sysNarrow & dec.typ[2];
  wire logic isTaskGate = isGate & dec.typ == ssd_pkg::TYPE_TASK;
  wire logic isCallGate = isGate & dec.typ == ssd_pkg::TYPE_CALL;
  wire logic isIntGate  = isGate & dec.typ == ssd_pkg::TYPE_INTR;

  // Target descriptor classification from its access byte
  wire logic [7:0] tgtAcc  = cmd.targetAccess;
  wire logic [2:0] tgtType = tgtAcc[2:0];
  wire logic tgtCode = tgtAcc[ssd_pkg::ACC_S] & tgtAcc[ssd_pkg::ACC_E];
  wire logic tgtTss  = !tgtAcc[ssd_pkg::ACC_S] & !tgtAcc[ssd_pkg::ACC_E] &
                       (tgtType == ssd_pkg::TYPE_TSS_AVAIL |
                        tgtType == ssd_pkg::TYPE_TSS_BUSY);
  wire logic tgtOk   = isTaskGate ? tgtTss : tgtCode;

  // Gate fault: not a gate, then not present, then wrong target
  wire logic [7:0] gateExc =
    !isGate      ? ssd_pkg::EXC_PROTECT :
    !dec.present ? ssd_pkg::EXC_NOT_PRESENT :
    !tgtOk       ? ssd_pkg::EXC_PROTECT :
                   ssd_pkg::EXC_NONE;
  wire logic gateOk = gateExc == ssd_pkg::EXC_NONE;

  // Call gate privilege change against the target's privilege
  wire logic privChg = isCallGate &&
                       tgtAcc[ssd_pkg::ACC_DPL +: 2] != ctrl.cpl;

  // Parameter words copied only by a privilege-changing call gate
  wire logic [4:0] copyCnt =
    (gateOk & privChg) ? dec.wordCount : 5'h00;

  // Entry point, unused by task gates
  wire logic [15:0] gateEntry =
    isTaskGate ? 16'h0000 : dec.destOffset;

  // Segment load fault: system or gate descriptors never cached
  wire logic segOk = {1'b0, cmd.seg} < SegCnt;
  wire logic [7:0] loadExc =
    (dec.isSystem | !segOk) ? ssd_pkg::EXC_PROTECT :
    !dec.present            ? ssd_pkg::EXC_NOT_PRESENT :
                              ssd_pkg::EXC_NONE;
  wire logic cacheWr = loadGo & loadExc == ssd_pkg::EXC_NONE;

  // System segment check with task state privilege
  wire logic isTss = dec.typ == ssd_pkg::TYPE_TSS_AVAIL |
                     dec.typ == ssd_pkg::TYPE_TSS_BUSY;
  wire logic isSysSeg = sysNarrow &
                        (isTss | dec.typ == ssd_pkg::TYPE_LDT);
  wire logic tssLow = isTss && dec.descriptorPrivilege < effPriv;
  wire logic [7:0] sysExc =
    !isSysSeg    ? ssd_pkg::EXC_PROTECT :
    !dec.present ? ssd_pkg::EXC_NOT_PRESENT :
    tssLow       ? ssd_pkg::EXC_PROTECT :
                   ssd_pkg::EXC_NONE;

  // Result of the current command
  wire logic [7:0] cmdExc = cmd.load ? loadExc :
                            cmd.gate ? gateExc : sysExc;
  wire ssd_pkg::ssd_stat_type next_status = '{
    pad:        11'h000,
    copyCount:  gateGo ? copyCnt : 5'h00,
    isSystem:   dec.isSystem,
    typ:        dec.typ,
    privChange: gateGo & gateOk & privChg,
    ifCleared:  gateGo & gateOk & isIntGate,
    taskSwitch: gateGo & gateOk & isTaskGate,
    done:       1'b1,
    exc:        cmdExc
  };

  // Read multiplexer; caches are deliberately absent
  wire logic [31:0] rdMux =
    address == ssd_pkg::OFF_DESC_LO ? descLo :
    address == ssd_pkg::OFF_DESC_HI ? descHi :
    address == ssd_pkg::OFF_SEL     ? {16'h0000, segmentSelector} :
    address == ssd_pkg::OFF_CTRL    ? 32'(ctrl) :
    address == ssd_pkg::OFF_STAT    ? 32'(status) :
    address == ssd_pkg::OFF_GATE    ? {gateSelector, entryOffset} :
    address == ssd_pkg::OFF_SELDEC  ? {selF.index, 3'h0, 16'(selF)} :
                                      32'h0000_0000;

  // Handshake and read data capture
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack      <= 1'b0;
      readdata <= ssd_pkg::RST_WORD;
    end
    else
    begin
      ack <= reqTake;
      if (reqTake & read)
        readdata <= rdMux;
    end
  end

  // Software-written registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      descLo          <= ssd_pkg::RST_WORD;
      descHi          <= ssd_pkg::RST_WORD;
      segmentSelector <= 16'h0000;
    end
    else if (wrGo)
    begin
      if (address == ssd_pkg::OFF_DESC_LO)
        descLo <= ssd_pkg::ssd_merge(descLo, writedata, byteenable);
      if (address == ssd_pkg::OFF_DESC_HI)
        descHi <= ssd_pkg::ssd_merge(descHi, writedata, byteenable);
      if (address == ssd_pkg::OFF_SEL)
        segmentSelector <= 16'(ssd_pkg::ssd_merge(32'(segmentSelector),
                                                  writedata, byteenable));
    end
  end

  // Control: interrupt gates drop the enable flag
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl <= ssd_pkg::ssd_ctrl_type'(ssd_pkg::RST_WORD);
    else if (wrGo && address == ssd_pkg::OFF_CTRL)
      ctrl <= ssd_pkg::ssd_ctrl_type'(
                ssd_pkg::ssd_merge(32'(ctrl), writedata, byteenable) & 32'h7);
    else if (gateGo & gateOk & isIntGate)
      ctrl.intEnable <= 1'b0;
  end

  assign intEnable = ctrl.intEnable;

  // Command results
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      status       <= ssd_pkg::ssd_stat_type'(ssd_pkg::RST_WORD);
      entryOffset  <= 16'h0000;
      gateSelector <= 16'h0000;
    end
    else if (anyGo)
    begin
      status <= next_status;
      if (gateGo & gateOk)
      begin
        entryOffset  <= gateEntry;
        gateSelector <= dec.destSelector;
      end
    end
  end

  // Hidden caches: whole entry written at once on a good load
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < SEG_COUNT; i++)
        cache[i] <= '0;
    end
    else if (cacheWr)
      cache[cmd.seg] <= '{base: dec.base, limit: dec.limit,
                          access: dec.access};
  end

  // References read the cache only, never memory
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      refCache <= '0;
    else
      refCache <= ({1'b0, refSeg} < SegCnt) ? cache[refSeg] : '0;
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  waitOne_a: assert property (
    (read | write) & waitrequest |=> !waitrequest)
    else $error("Bus request not answered after one wait");

  cacheHold_a: assert property (
    !(cacheWr && cmd.seg == 2'h0) |=> cache[0] == $past(cache[0]))
    else $error("Cache changed without a segment load");

  cacheFill_a: assert property (
    cacheWr && cmd.seg == 2'h0 |=>
      cache[0].base == $past(dec.base) &&
      cache[0].limit == $past(dec.limit) &&
      cache[0].access == $past(dec.access))
    else $error("Cache entry not loaded whole");

  sysNoCache_a: assert property (
    loadGo & dec.isSystem |-> !cacheWr ##1
      status.exc == ssd_pkg::EXC_PROTECT)
    else $error("System descriptor reached a cache");

  intClear_a: assert property (
    gateGo & gateOk & isIntGate |=> !intEnable ##1 !intEnable || $past(wrGo))
    else $error("Interrupt gate left interrupts enabled");

  trapKeep_a: assert property (
    gateGo && dec.typ == ssd_pkg::TYPE_TRAP |=> $stable(intEnable))
    else $error("Trap gate changed interrupt enable");

  gateAbsent_a: assert property (
    gateGo & isGate & !dec.present |=>
      status.exc == ssd_pkg::EXC_NOT_PRESENT && $stable(entryOffset))
    else $error("Absent gate did not raise 11");

  gateTarget_a: assert property (
    gateGo & isGate & dec.present & !tgtOk |=>
      status.exc == ssd_pkg::EXC_PROTECT)
    else $error("Wrong gate target did not raise 13");

  taskOffset_a: assert property (
    gateGo & gateOk & isTaskGate |=> entryOffset == 16'h0000 &&
      status.taskSwitch)
    else $error("Task gate offset was used");

  copyOnly_a: assert property (
    gateGo & !isCallGate |=> status.copyCount == 5'h00)
    else $error("Word count used outside a call gate");

  tssPriv_a: assert property (
    sysGo & isTss & dec.present & tssLow |=>
      status.exc == ssd_pkg::EXC_PROTECT)
    else $error("Task state privilege not applied");

  refServe_a: assert property (
    {1'b0, refSeg} < SegCnt |=> refCache == $past(cache[refSeg]))
    else $error("Reference not served from its cache");

  privCopy_a: assert property (
    gateGo & gateOk & privChg |=> status.copyCount == $past(dec.wordCount))
    else $error("Call gate word count not passed on");

  sysAbsent_a: assert property (
    sysGo & isSysSeg & !dec.present |=> status.exc == ssd_pkg::EXC_NOT_PRESENT)
    else $error("Absent system descriptor did not raise 11");

  gateEntry_a: assert property (
    gateGo & gateOk & !isTaskGate |=> entryOffset == $past(dec.destOffset))
    else $error("Gate entry point not taken from its offset");

endmodule : ssd_core
`default_nettype wire

// [logic/ssd_desc_decode.sv]
// Combinational field split of one eight-byte descriptor.
// Assumes the descriptor arrives as two little-endian words.
`timescale 1ns/1ps
`default_nettype none
module ssd_desc_decode (
  input  wire logic [63:0]   desc,   // Raw descriptor
  output ssd_pkg::ssd_desc_type fields  // Decoded fields
);

  // Segment and gate views share the same bytes
  assign fields = '{
    base:                desc[39:16],
    limit:               desc[15:0],
    access:              desc[47:40],
    destSelector:        desc[31:16],
    destOffset:          desc[15:0],
    wordCount:           desc[36:32],
    typ:                 desc[42:40],
    present:             desc[40+ssd_pkg::ACC_P],
    descriptorPrivilege: desc[40+ssd_pkg::ACC_DPL +: 2],
    isSystem:            !desc[40+ssd_pkg::ACC_S]
  };

endmodule : ssd_desc_decode
`default_nettype wire

// [logic/ssd_pkg.sv]
// Shared constants, types and helpers for the system descriptor decoder.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package ssd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_DESC_LO = 8'h00;
  localparam logic [7:0] OFF_DESC_HI = 8'h04;
  localparam logic [7:0] OFF_SEL     = 8'h08;
  localparam logic [7:0] OFF_CTRL    = 8'h0c;
  localparam logic [7:0] OFF_CMD     = 8'h10;
  localparam logic [7:0] OFF_STAT    = 8'h14;
  localparam logic [7:0] OFF_GATE    = 8'h18;
  localparam logic [7:0] OFF_SELDEC  = 8'h1c;

  // Descriptor type codes
  localparam logic [2:0] TYPE_TSS_AVAIL = 3'h1;
  localparam logic [2:0] TYPE_LDT       = 3'h2;
  localparam logic [2:0] TYPE_TSS_BUSY  = 3'h3;
  localparam logic [2:0] TYPE_CALL      = 3'h4;
  localparam logic [2:0] TYPE_TASK      = 3'h5;
  localparam logic [2:0] TYPE_INTR      = 3'h6;
  localparam logic [2:0] TYPE_TRAP      = 3'h7;

  // Exception vectors
  localparam logic [7:0] EXC_NONE        = 8'h00;
  localparam logic [7:0] EXC_NOT_PRESENT = 8'h0b;
  localparam logic [7:0] EXC_PROTECT     = 8'h0d;

  // Access byte field positions
  localparam int ACC_P   = 7;
  localparam int ACC_DPL = 5;
  localparam int ACC_S   = 4;
  localparam int ACC_E   = 3;

  // Largest number of entries in one descriptor table
  localparam int TABLE_ENTRIES = 8192;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [12:0] index;
    logic        tableIndicator;
    logic [1:0]  requestedPrivilegeLevel;
  } ssd_sel_type;

  typedef struct packed {
    logic [23:0] base;
    logic [15:0] limit;
    logic [7:0]  access;
    logic [15:0] destSelector;
    logic [15:0] destOffset;
    logic [4:0]  wordCount;
    logic [2:0]  typ;
    logic        present;
    logic [1:0]  descriptorPrivilege;
    logic        isSystem;
  } ssd_desc_type;

  typedef struct packed {
    logic [23:0] base;
    logic [15:0] limit;
    logic [7:0]  access;
  } ssd_cache_type;

  typedef struct packed {
    logic [28:0] pad;
    logic [1:0]  cpl;
    logic        intEnable;
  } ssd_ctrl_type;

  typedef struct packed {
    logic [15:0] pad;
    logic [7:0]  targetAccess;
    logic [2:0]  pad2;
    logic        sysCheck;
    logic        gate;
    logic        load;
    logic [1:0]  seg;
  } ssd_cmd_type;

  typedef struct packed {
    logic [10:0] pad;
    logic [4:0]  copyCount;
    logic        isSystem;
    logic [2:0]  typ;
    logic        privChange;
    logic        ifCleared;
    logic        taskSwitch;
    logic        done;
    logic [7:0]  exc;
  } ssd_stat_type;

  // Split a selector into index, table and privilege
  function automatic ssd_sel_type ssd_split_sel(input logic [15:0] sel);
    ssd_split_sel = '{index: sel[15:3], tableIndicator: sel[2],
                      requestedPrivilegeLevel: sel[1:0]};
  endfunction : ssd_split_sel

  // Merge write data under byte enables
  function automatic logic [31:0] ssd_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
    for (int i = 0; i < 4; i++)
      ssd_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction : ssd_merge

endpackage : ssd_pkg
